// [core/dapg_core.sv]
// register and data-ready logic of the dual converter front end
`timescale 1ns/1ps
module dapg_core
   import dapg_pkg::*;
(
   input wire logic clk, // 50 MHz clock
   input wire logic resetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic pready, // apb ready
   output logic [31:0] prdata, // apb read data
   output logic pslverr, // apb error
   input wire logic [23:0] convData0, // channel 0 conversion result
   input wire logic [23:0] convData1, // channel 1 conversion result
   input wire logic hostReadActive, // serial read transaction in progress
   output logic modulatorTick, // one pulse per modulator period
   output logic rateTick, // one pulse per output-rate period
   output logic convStrobe0, // sample channel 0 now (shifted by the phase code)
   output logic convStrobe1, // sample channel 1 now
   output logic dataReadyPinOut, // ready pin level, low is ready
   output logic dataReadyPinOe, // ready pin drive enable
   output dapg_analog_t analogCtrl // amplifier and timing settings
);
   // **************************************************************
   // functions
   // **************************************************************
   function automatic logic [8:0] ratioOf(input logic [1:0] code);
      logic [8:0] r;
      r = 9'h040;
      case (code)
         OSR_32: r = 9'h020;
         OSR_64: r = 9'h040;
         OSR_128: r = 9'h080;
         default: r = 9'h100;
      endcase
      return r;
   endfunction : ratioOf

   // sign position moves down as the ratio grows, range shrinks
   function automatic logic signed [8:0] phaseOf(input logic [7:0] p, input logic [1:0] oversampling_ratio);
      logic signed [8:0] v;
      v = 9'sh000;
      case (oversampling_ratio)
         OSR_32: v = {p[7], p};
         OSR_64: v = {{3{p[6]}}, p[5:0]};
         OSR_128: v = {{4{p[5]}}, p[4:0]};
         default: v = {{5{p[4]}}, p[3:0]};
      endcase
      return v;
   endfunction : phaseOf

   function automatic logic [5:0] gainOf(input logic [2:0] c);
      logic [5:0] g;
      g = 6'h01;
      if (c <= 3'h5) begin
         g = 6'(6'h01 << c);
      end
      return g;
   endfunction : gainOf

   function automatic logic [7:0] byteOf(input logic [23:0] w, input logic [1:0] n);
      logic [7:0] b;
      b = w[7:0];
      if (n == 2'h0) begin
         b = w[23:16];
      end else if (n == 2'h1) begin
         b = w[15:8];
      end
      return b;
   endfunction : byteOf

   // **************************************************************
   // state
   // **************************************************************
   dapg_state_t s;
   dapg_state_t next_s;
   logic [3:0] idx;
   logic [1:0] mode;
   logic off0;
   logic off1;
   logic signed [8:0] ph;
   logic [8:0] ratio;
   logic ev0;
   logic ev1;
   logic linkedEv;
   logic pulse;
   logic access;

   assign idx = paddr[5:2];
   assign access = psel && penable;
   assign mode = s.status[ST_MODE+:2];
   assign off0 = s.config_r[CF_RST] || s.config_r[CF_SHD];
   assign off1 = s.config_r[CF_RST+1] || s.config_r[CF_SHD+1];
   assign ph = phaseOf(s.phase, s.config_r[CF_OSR+:2]);
   assign ratio = ratioOf(s.config_r[CF_OSR+:2]);
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = s.prdata;
   assign modulatorTick = (s.divCnt == 6'h00);
   assign rateTick = modulatorTick && (s.modCnt == 9'h000);

   always_comb begin
      analogCtrl.ampGainCh0 = s.gain[GN_CH0+:3];
      analogCtrl.ampGainCh1 = s.gain[GN_CH1+:3];
      analogCtrl.gainFactorCh0 = gainOf(s.gain[GN_CH0+:3]);
      analogCtrl.gainFactorCh1 = gainOf(s.gain[GN_CH1+:3]);
      analogCtrl.biasDouble = s.gain[GN_BST+:2];
      analogCtrl.ratio = ratio;
      analogCtrl.phaseDelay = ph;
   end

   // channel 1 is the reference; a positive code delays channel 0
   assign convStrobe1 = rateTick && !off1;
   assign convStrobe0 = !off0 && modulatorTick &&
      ((ph <= 9'sh000) ? (s.modCnt == 9'(ratio + 9'(ph))) || (ph == 9'sh000 && rateTick)
                       : (s.dlyRun0 && s.dly0 == 9'h001));

   // **************************************************************
   // data-ready selection
   // **************************************************************
   assign ev0 = convStrobe0 && (s.settle0 == 2'h0 || !s.status[ST_LAT]);
   assign ev1 = convStrobe1 && (s.settle1 == 2'h0 || !s.status[ST_LAT]);
   // linked pair is ready when the later of the two has arrived
   assign linkedEv = !off0 && !off1 &&
      ((ev0 && (s.seen1 || ev1)) || (ev1 && s.seen0));

   always_comb begin
      pulse = 1'b0;
      case (mode)
         MODE_LINKED: pulse = linkedEv;
         MODE_CH0: pulse = ev0;
         MODE_CH1: pulse = ev1;
         default: pulse = ev0 || ev1;
      endcase
   end

   // low while ready; idle is driven high or released for a shared pull-up
   assign dataReadyPinOut = !s.readyPulse;
   assign dataReadyPinOe = s.readyPulse || s.status[ST_IDLE];

   // **************************************************************
   // next state
   // **************************************************************
   always_comb begin
      next_s = s;
      next_s.readyPulse = pulse;
      next_s.divCnt = modulatorTick ? 6'(MOD_DIV - 6'h01) : 6'(s.divCnt - 6'h01);
      if (modulatorTick) begin
         next_s.modCnt = (s.modCnt == 9'(ratio - 9'h001)) ? 9'h000 : 9'(s.modCnt + 9'h001);
         if (s.dlyRun0) begin
            next_s.dly0 = 9'(s.dly0 - 9'h001);
            next_s.dlyRun0 = (s.dly0 != 9'h001);
         end
      end
      if (rateTick && ph > 9'sh000) begin
         next_s.dly0 = 9'(ph);
         next_s.dlyRun0 = 1'b1;
      end
      if (convStrobe0 && s.settle0 != 2'h0) begin
         next_s.settle0 = 2'(s.settle0 - 2'h1);
      end
      if (convStrobe1 && s.settle1 != 2'h0) begin
         next_s.settle1 = 2'(s.settle1 - 2'h1);
      end
      if (off0) begin
         next_s.settle0 = SETTLE_PERIODS;
      end
      if (off1) begin
         next_s.settle1 = SETTLE_PERIODS;
      end
      // linked pairing tracker
      if (linkedEv || off0 || off1) begin
         next_s.seen0 = 1'b0;
         next_s.seen1 = 1'b0;
      end else begin
         if (ev0) begin
            next_s.seen0 = 1'b1;
         end
         if (ev1) begin
            next_s.seen1 = 1'b1;
         end
      end
      // capture into pending; all three bytes move at once
      if (mode == MODE_LINKED) begin
         if (linkedEv) begin
            next_s.pend0 = convData0;
            next_s.pend1 = convData1;
            next_s.pendV0 = 1'b1;
            next_s.pendV1 = 1'b1;
         end
      end else begin
         if (convStrobe0) begin
            next_s.pend0 = convData0;
            next_s.pendV0 = 1'b1;
         end
         if (convStrobe1) begin
            next_s.pend1 = convData1;
            next_s.pendV1 = 1'b1;
         end
      end
      // frozen during a read; newest kept pending and applied after
      if (!hostReadActive) begin
         if (s.pendV0) begin
            next_s.res0 = s.pend0;
            next_s.pendV0 = (mode == MODE_LINKED) ? linkedEv : convStrobe0;
         end
         if (s.pendV1) begin
            next_s.res1 = s.pend1;
            next_s.pendV1 = (mode == MODE_LINKED) ? linkedEv : convStrobe1;
         end
      end
      // register access, decode by word index
      if (access && pwrite && pstrb[0]) begin
         if (idx == IDX_PHASE) begin
            next_s.phase = pwdata[7:0];
         end else if (idx == IDX_GAIN) begin
            next_s.gain = pwdata[7:0];
         end else if (idx == IDX_STATUS) begin
            next_s.status = {2'h0, pwdata[5:2], 2'h0};
         end else if (idx == IDX_CONFIG) begin
            next_s.config_r = {2'h0, pwdata[5:0]};
         end
         // result addresses fall through untouched
      end
      // load in the setup cycle so the word already stands at the access edge
      if (psel && !penable && !pwrite) begin
         if (idx >= IDX_CH0_B2 && idx <= IDX_CH0_B0) begin
            next_s.prdata = {24'h000000, byteOf(s.res0, idx[1:0])};
         end else if (idx >= IDX_CH1_B2 && idx <= IDX_CH1_B0) begin
            next_s.prdata = {24'h000000, byteOf(s.res1, 2'(idx - IDX_CH1_B2))};
         end else if (idx == IDX_PHASE) begin
            next_s.prdata = {24'h000000, s.phase};
         end else if (idx == IDX_GAIN) begin
            next_s.prdata = {24'h000000, s.gain};
         end else if (idx == IDX_STATUS) begin
            next_s.prdata = {24'h000000, s.status};
         end else if (idx == IDX_CONFIG) begin
            next_s.prdata = {24'h000000, s.config_r};
         end else begin
            next_s.prdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.phase <= PHASE_RST;
         s.gain <= GAIN_RST;
         s.status <= STATUS_RST;
         s.config_r <= CONFIG_RST;
         s.settle0 <= SETTLE_PERIODS;
         s.settle1 <= SETTLE_PERIODS;
      end else begin
         s <= next_s;
      end
   end
endmodule : dapg_core

// [core/dapg_pkg.sv]
// package of constants and types for the dual converter register block
// **************************************************************
// Contract
// - result registers hold latest result, read only
// - results frozen during read, newest caught
// - three result bytes refresh together per period
// - channel 0 at 0x00-0x02, channel 1 at 0x03-0x05
// - phase register 0x07, signed, resets zero
// - positive code delays channel 0 behind 1
// - delay equals code times modulator period
// - sign bit and range follow oversampling ratio
// - gain register 0x08 field layout, resets zero
// - gain codes 1..32, reserved codes gain one
// - bias_double bits double channel bias currents
// - latency bit suppresses first three pulses
// - idle ready pin driven high or released
// - modes 01/10/11 pick channel, independent
// - 11 both, 10 ch1, 01 ch0, 00 lagging
// - independent modes capture read channel at start
// - linked mode captures both at lagging event
// - linked pair held during host read
// - linked pair acts as one 48-bit result
// - linked mode: channel off means no pulses
// - unlinked: off channel's pulses simply absent
// - ratio field 00=32 01=64 10=128 11=256
// **************************************************************
package dapg_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [3:0] IDX_CH0_B2 = 4'h0;
   localparam logic [3:0] IDX_CH0_B0 = 4'h2;
   localparam logic [3:0] IDX_CH1_B2 = 4'h3;
   localparam logic [3:0] IDX_CH1_B0 = 4'h5;
   localparam logic [3:0] IDX_PHASE = 4'h7;
   localparam logic [3:0] IDX_GAIN = 4'h8;
   localparam logic [3:0] IDX_STATUS = 4'h9;
   localparam logic [3:0] IDX_CONFIG = 4'ha;
   localparam logic [7:0] PHASE_RST = 8'h00;
   localparam logic [7:0] GAIN_RST = 8'h00;
   // status: bit5 latency, bit4 idle drive, bits3:2 ready mode
   localparam logic [7:0] STATUS_RST = 8'h20;
   localparam int unsigned ST_LAT = 5;
   localparam int unsigned ST_IDLE = 4;
   localparam int unsigned ST_MODE = 2;
   // config: bits5:4 ratio, bits3:2 reset per channel, bits1:0 shutdown
   localparam logic [7:0] CONFIG_RST = 8'h10;
   localparam int unsigned CF_OSR = 4;
   localparam int unsigned CF_RST = 2;
   localparam int unsigned CF_SHD = 0;
   localparam int unsigned GN_CH1 = 5;
   localparam int unsigned GN_BST = 3;
   localparam int unsigned GN_CH0 = 0;
   localparam logic [1:0] OSR_32 = 2'h0;
   localparam logic [1:0] OSR_64 = 2'h1;
   localparam logic [1:0] OSR_128 = 2'h2;
   localparam logic [1:0] OSR_256 = 2'h3;
   localparam logic [1:0] MODE_LINKED = 2'h0;
   localparam logic [1:0] MODE_CH0 = 2'h1;
   localparam logic [1:0] MODE_CH1 = 2'h2;
   localparam logic [1:0] MODE_BOTH = 2'h3;
   localparam logic [1:0] SETTLE_PERIODS = 2'h3;
   // modulator clock divider; output rate is modulator rate / ratio
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned MOD_HZ = 1000000;
   localparam logic [5:0] MOD_DIV = 6'(CLK_HZ / MOD_HZ);
   typedef struct packed {
      logic [7:0] phase;
      logic [7:0] gain;
      logic [7:0] status;
      logic [7:0] config_r;
      logic [23:0] res0;
      logic [23:0] res1;
      logic [23:0] pend0;
      logic [23:0] pend1;
      logic pendV0;
      logic pendV1;
      logic [5:0] divCnt;
      logic [8:0] modCnt;
      logic [8:0] dly0;
      logic dlyRun0;
      logic [1:0] settle0;
      logic [1:0] settle1;
      logic seen0;
      logic seen1;
      logic readyPulse;
      logic [31:0] prdata;
   } dapg_state_t;
   typedef struct packed {
      logic [2:0] ampGainCh0;
      logic [2:0] ampGainCh1;
      logic [5:0] gainFactorCh0;
      logic [5:0] gainFactorCh1;
      logic [1:0] biasDouble;
      logic [8:0] ratio;
      logic signed [8:0] phaseDelay;
   } dapg_analog_t;
endpackage : dapg_pkg

// [sim/dapg_monitor.sv]
// assertions on the converter register block ports
`timescale 1ns/1ps
module dapg_monitor
   import dapg_pkg::*;
(
   input wire logic clk, // clock
   input wire logic resetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb strobes
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic dataReadyPinOut, // ready pin level
   input wire logic dataReadyPinOe, // ready pin enable
   input wire dapg_analog_t analogCtrl // analog settings
);
   // *****
   // checks
   // *****
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire wrAcc = psel && penable && pwrite && pstrb[0];
   chk_zero_wait: assert property (pready && !pslverr)
      else $error("apb answer not clean");
   chk_pulse_drive: assert property (!dataReadyPinOut |-> dataReadyPinOe)
      else $error("ready pulse not driven");
   chk_pulse_width: assert property ($fell(dataReadyPinOut) |=> dataReadyPinOut)
      else $error("ready pulse too long");
   chk_idle_high: assert property (wrAcc && paddr == 8'h24 && pwdata[4] |=> dataReadyPinOe [*8])
      else $error("idle pin not driven");
   chk_gain_fields: assert property (wrAcc && paddr == 8'h20 |=>
      {analogCtrl.ampGainCh1, analogCtrl.biasDouble, analogCtrl.ampGainCh0} == $past(pwdata[7:0]))
      else $error("gain fields wrong");
   chk_gain0_map: assert property (analogCtrl.gainFactorCh0 ==
      (analogCtrl.ampGainCh0 < 3'h6 ? 6'h1 << analogCtrl.ampGainCh0 : 6'h1))
      else $error("channel 0 gain wrong");
   chk_gain1_map: assert property (analogCtrl.gainFactorCh1 ==
      (analogCtrl.ampGainCh1 < 3'h6 ? 6'h1 << analogCtrl.ampGainCh1 : 6'h1))
      else $error("channel 1 gain wrong");
   chk_ratio_map: assert property (wrAcc && paddr == 8'h28 |=>
      analogCtrl.ratio == 9'h020 << $past(pwdata[5:4]))
      else $error("ratio wrong");
   chk_phase_sign: assert property (wrAcc && paddr == 8'h1c && analogCtrl.ratio == 9'h020 |=>
      analogCtrl.phaseDelay == {$past(pwdata[7]), $past(pwdata[7:0])})
      else $error("phase code wrong");
   cover property ($fell(dataReadyPinOut));
   cover property (wrAcc && paddr == 8'h20);
   cover property (dataReadyPinOe && dataReadyPinOut);
endmodule : dapg_monitor
bind dapg_core dapg_monitor dapg_monitor_i (.clk(clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .pslverr(pslverr), .dataReadyPinOut(dataReadyPinOut),
   .dataReadyPinOe(dataReadyPinOe), .analogCtrl(analogCtrl));

// [sim/dapg_conv_model.sv]
// conversion source feeding the register block
`timescale 1ns/1ps
module dapg_conv_model
   import dapg_pkg::*;
(
   input wire logic clk, // clock
   input wire logic resetn, // reset, active low
   input wire logic convStrobe0, // channel 0 sample
   input wire logic convStrobe1, // channel 1 sample
   output logic [23:0] convData0, // channel 0 value
   output logic [23:0] convData1 // channel 1 value
);
   // new value after every sample, so a stale capture shows
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         convData0 <= 24'h800001;
         convData1 <= 24'h7ffffe;
      end else begin
         if (convStrobe0) convData0 <= convData0 + 24'h010203;
         if (convStrobe1) convData1 <= convData1 + 24'h0a0b0c;
      end
   end
endmodule : dapg_conv_model

// [sim/tb_top.sv]
// self-checking bench for the converter register block
`timescale 1ns/1ps
module tb_top;
   import dapg_pkg::*;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, hostReadActive = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, prdata;
   logic [3:0] pstrb = 4'h1;
   logic pready, pslverr, modTick, rateTick, s0, s1, pinOut, pinOe;
   logic [23:0] d0, d1, v;
   dapg_analog_t an;
   int fails = 0, n_compared = 0, cyc = 0, k;
   logic [7:0] st[6] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h3c, 8'h30};
   logic [7:0] cf[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
   int ex[6] = '{2, 2, 2, 4, 2, 0};
   dapg_core dapg_core_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .convData0(d0), .convData1(d1),
      .hostReadActive(hostReadActive), .modulatorTick(modTick), .rateTick(rateTick),
      .convStrobe0(s0), .convStrobe1(s1), .dataReadyPinOut(pinOut),
      .dataReadyPinOe(pinOe), .analogCtrl(an));
   dapg_conv_model dapg_conv_model_i (.clk(clk), .resetn(resetn), .convStrobe0(s0),
      .convStrobe1(s1), .convData0(d0), .convData1(d1));
   initial forever #10 clk = ~clk;
   // *****
   // helpers
   // *****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   // read data stands from the setup edge and is taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask : apb
   task automatic ticks(input int n);
      repeat (n) do @(posedge clk); while (rateTick !== 1'b1);
   endtask : ticks
   task automatic rdres(input logic [7:0] a);
      for (int i = 0; i < 3; i++) begin
         apb(0, a + 8'(4 * i), 0);
         v = {v[15:0], rd[7:0]};
      end
   endtask : rdres
   task automatic gap(input logic first, input int exp);
      k = 0;
      do @(posedge clk); while ((first ? s1 : s0) !== 1'b1);
      do begin
         @(posedge clk);
         k++;
      end while ((first ? s0 : s1) !== 1'b1);
      check(k, exp);
   endtask : gap
   task automatic pulses(input int n);
      k = 0;
      repeat (n) begin
         @(posedge clk);
         if (pinOut === 1'b0) k++;
      end
   endtask : pulses
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   // *****
   // scenarios
   // *****
   task automatic t_regs;
      apb(0, 8'h1c, 0);
      check(rd, 0);
      apb(0, 8'h20, 0);
      check(rd, 0);
      for (int i = 0; i < 8; i++) begin
         apb(1, 8'h20, 32'({3'(i), 2'(i), 3'(i)}));
         check(an.gainFactorCh0, i < 6 ? 1 << i : 1);
      end
      apb(0, 8'h20, 0);
      check(rd, 8'hff);
      apb(1, 8'h28, 0);
      apb(1, 8'h1c, 8'h85);
      apb(0, 8'h1c, 0);
      check(rd, 8'h85);
   endtask : t_regs
   task automatic t_phase;
      apb(1, 8'h1c, 8'h05);
      ticks(2);
      gap(1, 250);
      apb(1, 8'h1c, 8'hfd);
      ticks(2);
      gap(0, 150);
   endtask : t_phase
   task automatic t_results;
      do @(posedge clk); while (s1 !== 1'b1);
      @(posedge clk);
      apb(1, 8'h00, 32'hffffffff);
      rdres(8'h00);
      check(v, d0 - 24'h010203);
      hostReadActive <= 1;
      rdres(8'h0c);
      check(v, d1 - 24'h0a0b0c);
      ticks(2);
      rdres(8'h0c);
      check(v, d1 - 24'h0a0b0c - 24'h0a0b0c * 2);
      hostReadActive <= 0;
      repeat (3) @(posedge clk);
      rdres(8'h0c);
      check(v, d1 - 24'h0a0b0c);
   endtask : t_results
   task automatic t_modes;
      for (int i = 0; i < 6; i++) begin
         apb(1, 8'h28, cf[i]);
         apb(1, 8'h24, st[i]);
         ticks(1);
         pulses(3200);
         check(k, ex[i]);
      end
   endtask : t_modes
   task automatic t_latency;
      apb(1, 8'h24, 8'h28);
      apb(1, 8'h28, 8'h08);
      apb(1, 8'h28, 8'h00);
      pulses(3000);
      check(k, 0);
      ticks(3);
      pulses(3200);
      check(k, 2);
   endtask : t_latency
   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      t_regs();
      t_phase();
      apb(1, 8'h1c, 0);
      t_results();
      apb(1, 8'h1c, 8'h05);
      t_modes();
      t_latency();
      wrap_up();
   end
endmodule : tb_top
